//--- verilog/dds_axi_stream_sideband.sv
// sideband, channel and configuration handling of a multi-channel synthesizer
// assumes axi4-stream neighbours on the phase input and both outputs, and an apb master
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - last-transfer marker exists only with more than one channel
// - framing not-required drives no last marker anywhere
// - vector framing marks the final channel of each cycle with tlast
// - packet framing carries input tlast with data latency, used inside only by packet sync
// - config-triggered framing as vector, input tlast adopts pending config
// - back-pressure on: outputs obey valid/ready, downstream may stall
// - input tready follows the same back-pressure setting
// - no user sideband selected means tuser carries nothing
// - channel-id mode: tuser holds the transfer's channel index
// - user mode: input tuser passed untouched to the outputs
// - combined mode: user field above channel index, index minimal width
// - user field width is a build parameter, carried without change
// - vector sync: new config takes effect at a fresh channel cycle
// - packet sync only with packet framing, input tlast applies config
// - phase step is fixed, programmable or streaming at build time
// - programmable step has channel select, data and write enable
// - phase step spans zero to two to the phase width minus one
// - phase shift is none, fixed, programmable or streaming
// - each channel holds its own shift, a fraction of a full turn
// - each channel holds its own step, hence its own frequency
// - one to sixteen channels share one datapath in turn
// - registered active-low clear overrides enable, hold two cycles
// - with clock enable low channel, accumulators and outputs hold; apb loads and clear still act
module dds_axi_stream_sideband
   import dds_pkg::*;
#(
   parameter int NUM_CHANNELS = 1,
   parameter int PHASE_WIDTH = 16,
   parameter int USER_WIDTH = 1,
   parameter dds_frame_t FRAMING = DDS_FRAME_NONE,
   parameter bit BACKPRESSURE = 1'b0,
   parameter dds_user_t USER_IN = DDS_USER_NONE,
   parameter dds_user_t USER_DATA = DDS_USER_NONE,
   parameter dds_user_t USER_PHASE = DDS_USER_NONE,
   parameter dds_sync_t SYNC_MODE = DDS_SYNC_VECTOR,
   parameter dds_src_t STEP_SRC = DDS_SRC_PROG,
   parameter dds_src_t SHIFT_SRC = DDS_SRC_NONE,
   parameter logic [PHASE_WIDTH-1:0] FIXED_STEP = '0,
   parameter logic [PHASE_WIDTH-1:0] FIXED_SHIFT = '0,
   localparam int CHW = (NUM_CHANNELS > 1) ? $clog2(NUM_CHANNELS) : 1,
   localparam int TUW = USER_WIDTH + CHW
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic aclken,
   input wire logic clearN,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   input wire logic sPhaseValid,
   output logic sPhaseReady,
   input wire logic [2*PHASE_WIDTH-1:0] sPhaseData,
   input wire logic sPhaseLast,
   input wire logic [TUW-1:0] sPhaseUser,
   output logic mDataValid,
   input wire logic mDataReady,
   output logic [PHASE_WIDTH-1:0] mDataData,
   output logic mDataLast,
   output logic [TUW-1:0] mDataUser,
   output logic mPhaseValid,
   input wire logic mPhaseReady,
   output logic [PHASE_WIDTH-1:0] mPhasePhase,
   output logic mPhaseLast,
   output logic [TUW-1:0] mPhaseUser
);

   // build-time features derived from the parameters
   localparam bit HAS_IN = (STEP_SRC == DDS_SRC_STREAM) || (SHIFT_SRC == DDS_SRC_STREAM);
   localparam bit LAST_ON = (NUM_CHANNELS > 1) && (FRAMING != DDS_FRAME_NONE);
   localparam bit PKT_SYNC = (SYNC_MODE == DDS_SYNC_PACKET) && (FRAMING == DDS_FRAME_PACKET);
   localparam bit SHIFT_LOADABLE = (SHIFT_SRC == DDS_SRC_FIXED) || (SHIFT_SRC == DDS_SRC_PROG);
   localparam logic [CHW-1:0] LAST_CHAN = CHW'(NUM_CHANNELS - 1);

   // assemble an output tuser from the user field and the channel index
   function automatic logic [TUW-1:0] packUser(input dds_user_t mode,
                                               input logic [DDS_MAX_UW-1:0] user,
                                               input logic [DDS_CHSEL_W-1:0] chan);
      logic [TUW-1:0] u;
      u = '0;
      case (mode)
         DDS_USER_CHAN: u = TUW'(chan[CHW-1:0]);
         DDS_USER_FIELD: u = TUW'(user[USER_WIDTH-1:0]);
         DDS_USER_BOTH: u = {user[USER_WIDTH-1:0], chan[CHW-1:0]};
         default: u = '0;
      endcase
      return u;
   endfunction

   // control and status state
   logic clearReg;
   logic runBit;
   logic [DDS_CHSEL_W-1:0] chSel;
   logic [CHW-1:0] chan;
   logic pendFlag;
   logic [PHASE_WIDTH-1:0] acc [NUM_CHANNELS];
   logic [PHASE_WIDTH-1:0] actStep [NUM_CHANNELS];
   logic [PHASE_WIDTH-1:0] pendStep [NUM_CHANNELS];
   logic [PHASE_WIDTH-1:0] actShift [NUM_CHANNELS];
   logic [PHASE_WIDTH-1:0] pendShift [NUM_CHANNELS];
   dds_beat_t outMain;
   dds_beat_t skid;
   logic outValid;
   logic skidValid;

   // clear after its input register, and the qualified enable
   wire syncClear = rst || clearReg;
   wire en = aclken && runBit;

   // apb decode
   wire apbSetup = psel && !penable;
   wire apbWr = psel && penable && pready && pwrite;
   wire hitCtrl = paddr == DDS_OFF_CTRL;
   wire hitSel = paddr == DDS_OFF_CHAN_SEL;
   wire hitStep = paddr == DDS_OFF_STEP_LOAD;
   wire hitShift = paddr == DDS_OFF_SHIFT_LOAD;
   wire hitStat = paddr == DDS_OFF_STATUS;
   wire hitAny = hitCtrl || hitSel || hitStep || hitShift || hitStat;
   // one spare bit so that a count of sixteen channels does not wrap to zero
   wire selOk = {1'b0, chSel} < (DDS_CHSEL_W + 1)'(NUM_CHANNELS);
   wire [CHW-1:0] selIdx = selOk ? chSel[CHW-1:0] : '0;
   wire wrStep = apbWr && hitStep && (STEP_SRC == DDS_SRC_PROG) && selOk;
   wire wrShift = apbWr && hitShift && SHIFT_LOADABLE && selOk;
   wire [PHASE_WIDTH-1:0] wrValue = pwdata[PHASE_WIDTH-1:0];

   // register read mux
   wire [31:0] rdStep = selOk ? 32'(actStep[selIdx]) : 32'h0000_0000;
   wire [31:0] rdShift = selOk ? 32'(actShift[selIdx]) : 32'h0000_0000;
   wire [31:0] rdStat = (32'(pendFlag) << DDS_STAT_PEND_BIT)
                      | (32'(outValid) << DDS_STAT_OUTV_BIT)
                      | (32'(chan) << DDS_STAT_CHAN_POS);
   wire [31:0] rdMux = hitCtrl ? (32'(runBit) << DDS_CTRL_RUN_BIT)
                     : hitSel ? 32'(chSel)
                     : hitStep ? rdStep
                     : hitShift ? rdShift
                     : hitStat ? rdStat
                     : 32'h0000_0000;

   // input stream view: streaming values in their own tdata subfields
   wire inValid = HAS_IN ? sPhaseValid : 1'b1;
   wire inLast = HAS_IN ? sPhaseLast : (chan == LAST_CHAN);
   wire [PHASE_WIDTH-1:0] strStep = sPhaseData[PHASE_WIDTH-1:0];
   wire [PHASE_WIDTH-1:0] strShift = (STEP_SRC == DDS_SRC_STREAM)
                                   ? sPhaseData[2*PHASE_WIDTH-1:PHASE_WIDTH]
                                   : sPhaseData[PHASE_WIDTH-1:0];
   wire [DDS_MAX_UW-1:0] userIn = (USER_IN == DDS_USER_BOTH)
                                ? DDS_MAX_UW'(sPhaseUser[TUW-1:CHW])
                                : DDS_MAX_UW'(sPhaseUser[USER_WIDTH-1:0]);

   // per-channel step and shift in use this transfer
   wire [PHASE_WIDTH-1:0] curStep = (STEP_SRC == DDS_SRC_STREAM) ? strStep
                                  : (STEP_SRC == DDS_SRC_FIXED) ? FIXED_STEP
                                  : actStep[chan];
   wire [PHASE_WIDTH-1:0] curShift = (SHIFT_SRC == DDS_SRC_STREAM) ? strShift
                                   : (SHIFT_SRC == DDS_SRC_NONE) ? '0
                                   : actShift[chan];

   // output handshake with a skid stage so tready can come from a flop
   wire dnReady = BACKPRESSURE ? (mDataReady && mPhaseReady) : 1'b1;
   wire accept = en && inValid && sPhaseReady;
   wire pop = en && outValid && dnReady;
   wire toSkid = accept && outValid && !pop;
   wire next_skidValid = toSkid ? 1'b1 : (pop ? 1'b0 : skidValid);
   wire next_outValid = accept || (outValid && !pop) || (pop && skidValid);
   wire chanWrap = chan == LAST_CHAN;

   // the beat built from the current channel
   dds_beat_t beat;
   assign beat.data = DDS_MAX_PW'(PHASE_WIDTH'(acc[chan] + curShift));
   assign beat.phase = DDS_MAX_PW'(acc[chan]);
   assign beat.last = (FRAMING == DDS_FRAME_PACKET) ? sPhaseLast && HAS_IN
                    : chanWrap;
   assign beat.user = userIn;
   assign beat.chan = DDS_CHSEL_W'(chan);

   // adoption trigger for pending configuration
   wire lastTrig = (FRAMING == DDS_FRAME_CFGTRIG) || PKT_SYNC;
   wire adopt = pendFlag && accept && (lastTrig ? inLast : chanWrap);

   // registered clear input and apb slave
   always_ff @(posedge clk)
   begin
      clearReg <= rst ? 1'b0 : !clearN;
      pready <= rst ? 1'b0 : (apbSetup && !pready);
      pslverr <= rst ? 1'b0 : (apbSetup && !pready && !hitAny);
      prdata <= (rst || !(apbSetup && !pwrite)) ? 32'h0000_0000 : rdMux;
   end

   // software controls
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         runBit <= DDS_CTRL_RESET[DDS_CTRL_RUN_BIT];
         chSel <= DDS_CHSEL_RESET;
      end
      else
      begin
         if (apbWr && hitCtrl && pstrb[0])
            runBit <= pwdata[DDS_CTRL_RUN_BIT];
         if (apbWr && hitSel && pstrb[0])
            chSel <= pwdata[DDS_CHSEL_W-1:0];
      end
   end

   // pending flag: a new load wins over a same-cycle adoption
   always_ff @(posedge clk)
   begin
      if (syncClear)
         pendFlag <= 1'b0;
      else if (wrStep || wrShift)
         pendFlag <= 1'b1;
      else if (adopt)
         pendFlag <= 1'b0;
   end

   // channel counter, one step per accepted transfer
   always_ff @(posedge clk)
   begin
      if (syncClear)
         chan <= '0;
      else if (accept)
         chan <= chanWrap ? '0 : CHW'(chan + 1'b1);
   end

   // per-channel accumulators, pending and active configuration
   for (genvar c = 0; c < NUM_CHANNELS; c++)
   begin : g_chan
      always_ff @(posedge clk)
      begin
         if (syncClear)
         begin
            acc[c] <= '0;
            actStep[c] <= FIXED_STEP;
            pendStep[c] <= FIXED_STEP;
            actShift[c] <= FIXED_SHIFT;
            pendShift[c] <= FIXED_SHIFT;
         end
         else
         begin
            if (accept && chan == CHW'(c))
               acc[c] <= PHASE_WIDTH'(acc[c] + curStep);
            if (wrStep && selIdx == CHW'(c))
               pendStep[c] <= wrValue;
            if (wrShift && selIdx == CHW'(c))
               pendShift[c] <= wrValue;
            if (adopt)
            begin
               actStep[c] <= pendStep[c];
               actShift[c] <= pendShift[c];
            end
         end
      end
   end

   // output stage and skid buffer, held while the enable is low
   always_ff @(posedge clk)
   begin
      if (syncClear)
      begin
         outValid <= 1'b0;
         skidValid <= 1'b0;
         sPhaseReady <= 1'b0;
         outMain <= '0;
         skid <= '0;
      end
      else
      begin
         outValid <= next_outValid;
         skidValid <= next_skidValid;
         sPhaseReady <= !next_skidValid;
         if (toSkid)
            skid <= beat;
         if (accept && !toSkid)
            outMain <= beat;
         else if (pop && skidValid)
            outMain <= skid;
      end
   end

   // output ports: straight from the output stage flops
   assign mDataValid = outValid;
   assign mPhaseValid = outValid;
   assign mDataData = outMain.data[PHASE_WIDTH-1:0];
   assign mPhasePhase = outMain.phase[PHASE_WIDTH-1:0];
   assign mDataLast = LAST_ON && outMain.last;
   assign mPhaseLast = LAST_ON && outMain.last;
   assign mDataUser = packUser(USER_DATA, outMain.user, outMain.chan);
   assign mPhaseUser = packUser(USER_PHASE, outMain.user, outMain.chan);

   // checks on the block's own behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_noFrameNoLast;
      !LAST_ON |-> !mDataLast && !mPhaseLast;
   endproperty
   a_noFrameNoLast: assert property (p_noFrameNoLast)
      else $error("last marker present while framing is off");

   property p_vectorLast;
      (LAST_ON && FRAMING != DDS_FRAME_PACKET && mDataValid)
         |-> mDataLast == (outMain.chan == DDS_CHSEL_W'(NUM_CHANNELS - 1));
   endproperty
   a_vectorLast: assert property (p_vectorLast)
      else $error("vector tlast not on the final channel");

   property p_packetLatency;
      (FRAMING == DDS_FRAME_PACKET && HAS_IN && accept && !outValid)
         |=> outValid && (outMain.last == $past(sPhaseLast));
   endproperty
   a_packetLatency: assert property (p_packetLatency)
      else $error("packet tlast not carried with its data");

   property p_stallHolds;
      (mDataValid && !dnReady && en && !syncClear)
         |=> mDataValid && $stable(mDataData) && $stable(mDataUser);
   endproperty
   a_stallHolds: assert property (p_stallHolds)
      else $error("output changed while stalled");

   property p_inputReady;
      (!BACKPRESSURE && !syncClear) |=> sPhaseReady || $past(syncClear);
   endproperty
   a_inputReady: assert property (p_inputReady)
      else $error("input ready dropped without back-pressure");

   property p_chanWrap;
      (accept && chanWrap && !syncClear) |=> chan == '0;
   endproperty
   a_chanWrap: assert property (p_chanWrap)
      else $error("channel index did not wrap to zero");

   property p_adoptClears;
      (adopt && !wrStep && !wrShift && !syncClear) |=> !pendFlag;
   endproperty
   a_adoptClears: assert property (p_adoptClears)
      else $error("pending config not adopted");

   property p_pendHeld;
      (pendFlag && !(accept && (lastTrig ? inLast : chanWrap)) && !syncClear) |=> pendFlag;
   endproperty
   a_pendHeld: assert property (p_pendHeld)
      else $error("config adopted without its trigger");

   property p_clearEmpties;
      (!clearN) |=> ##1 (chan == '0) && !outValid && !pendFlag;
   endproperty
   a_clearEmpties: assert property (p_clearEmpties)
      else $error("clear did not empty the datapath");

   property p_enableHolds;
      (!aclken && !syncClear) |=> $stable(chan) && $stable(outValid) && $stable(skidValid);
   endproperty
   a_enableHolds: assert property (p_enableHolds)
      else $error("state advanced with enable low");

endmodule

`default_nettype wire

//--- verilog/dds_pkg.sv
// constants, modes and the output beat carrier for the dds stream sideband block
// assumes one 100 MHz clock and an apb slave port with 32-bit data
package dds_pkg;

   // apb register byte offsets
   localparam logic [11:0] DDS_OFF_CTRL = 12'h000;
   localparam logic [11:0] DDS_OFF_CHAN_SEL = 12'h004;
   localparam logic [11:0] DDS_OFF_STEP_LOAD = 12'h008;
   localparam logic [11:0] DDS_OFF_SHIFT_LOAD = 12'h00C;
   localparam logic [11:0] DDS_OFF_STATUS = 12'h010;

   // control register fields and reset value
   localparam int DDS_CTRL_RUN_BIT = 0;
   localparam logic [31:0] DDS_CTRL_RESET = 32'h0000_0001;

   // status register fields
   localparam int DDS_STAT_PEND_BIT = 0;
   localparam int DDS_STAT_OUTV_BIT = 1;
   localparam int DDS_STAT_CHAN_POS = 4;

   // channel select field width and reset value
   localparam int DDS_CHSEL_W = 4;
   localparam logic [3:0] DDS_CHSEL_RESET = 4'h0;

   // widest phase and user fields the carrier holds
   localparam int DDS_MAX_PW = 32;
   localparam int DDS_MAX_UW = 16;
   localparam int DDS_MAX_CH = 16;

   // tlast framing, gray coded
   typedef enum logic [1:0] {
      DDS_FRAME_NONE = 2'b00,
      DDS_FRAME_VECTOR = 2'b01,
      DDS_FRAME_PACKET = 2'b11,
      DDS_FRAME_CFGTRIG = 2'b10
   } dds_frame_t;

   // tuser content of one stream
   typedef enum logic [1:0] {
      DDS_USER_NONE = 2'b00,
      DDS_USER_CHAN = 2'b01,
      DDS_USER_FIELD = 2'b11,
      DDS_USER_BOTH = 2'b10
   } dds_user_t;

   // source of phase step or phase shift
   typedef enum logic [1:0] {
      DDS_SRC_NONE = 2'b00,
      DDS_SRC_FIXED = 2'b01,
      DDS_SRC_PROG = 2'b11,
      DDS_SRC_STREAM = 2'b10
   } dds_src_t;

   // moment at which pending configuration is adopted
   typedef enum logic {
      DDS_SYNC_VECTOR = 1'b0,
      DDS_SYNC_PACKET = 1'b1
   } dds_sync_t;

   // one output beat shared by the data and phase output streams
   typedef struct packed {
      logic [DDS_MAX_PW-1:0] data;
      logic [DDS_MAX_PW-1:0] phase;
      logic last;
      logic [DDS_MAX_UW-1:0] user;
      logic [DDS_CHSEL_W-1:0] chan;
   } dds_beat_t;

endpackage

//--- verification/dds_stream_sink.sv
// downstream sink model for the data and phase output streams
// assumes both outputs share one handshake, so one ready drives both
`timescale 1ns/1ns
`default_nettype none
module dds_stream_sink
   import dds_pkg::*;
#(
   parameter int W = 46
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic stall,
   input wire logic valid,
   input wire logic [W-1:0] beat,
   output logic ready,
   output int holdErrs
);
   logic held;
   logic [W-1:0] heldBeat;
   // ready toggles while stalling; a refused beat must stay put
   always @(posedge clk)
   begin
      if (rst)
      begin
         ready <= 1'b0;
         held <= 1'b0;
         holdErrs <= 0;
      end
      else
      begin
         ready <= stall ? ~ready : 1'b1;
         if (held && (valid !== 1'b1 || beat !== heldBeat))
            holdErrs <= holdErrs + 1;
         held <= (valid === 1'b1) && !ready;
         heldBeat <= beat;
      end
   end
endmodule
`default_nettype wire

//--- verification/dds_axi_stream_sideband_tb.sv
// self-checking bench: apb set-up, four-channel streaming shift, stalls, enable, clear
// assumes vector framing with back-pressure and the sink model on the outputs
`timescale 1ns/1ns
`default_nettype none
module dds_axi_stream_sideband_tb;
   import dds_pkg::*;
   logic clk = 0, rst = 1, aclken = 1, clearN = 1, stall = 0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic sPhaseValid = 0, sPhaseReady, sPhaseLast = 0, rdy, err;
   logic [31:0] sPhaseData = '0;
   logic [5:0] sPhaseUser = '0, mDataUser, mPhaseUser;
   logic mDataValid, mDataLast, mPhaseValid, mPhaseLast;
   logic singleValid, singleLast, singleReady;
   logic [15:0] mDataData, mPhasePhase;
   logic [15:0] acc [4], act [4], pend [4];
   logic [45:0] expQ [$];
   logic [45:0] got;
   int mismatches = 0, checks_done = 0, cycles = 0, holdErrs;
   localparam logic [15:0] STEPS [4] = '{16'h0001, 16'h0100, 16'h1234, 16'hFFFF};
   wire logic [45:0] outBeat = {mDataData, mPhasePhase, mDataLast, mPhaseLast, mDataUser,
      mPhaseUser};

   dds_axi_stream_sideband #(.NUM_CHANNELS(4), .USER_WIDTH(4), .FRAMING(DDS_FRAME_VECTOR),
      .BACKPRESSURE(1'b1), .USER_IN(DDS_USER_BOTH), .USER_DATA(DDS_USER_BOTH),
      .USER_PHASE(DDS_USER_CHAN), .STEP_SRC(DDS_SRC_PROG), .SHIFT_SRC(DDS_SRC_STREAM)) u_dut (
      .clk(clk), .rst(rst), .aclken(aclken), .clearN(clearN), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .sPhaseValid(sPhaseValid), .sPhaseReady(sPhaseReady),
      .sPhaseData(sPhaseData), .sPhaseLast(sPhaseLast), .sPhaseUser(sPhaseUser),
      .mDataValid(mDataValid), .mDataReady(rdy), .mDataData(mDataData), .mDataLast(mDataLast),
      .mDataUser(mDataUser), .mPhaseValid(mPhaseValid), .mPhaseReady(rdy),
      .mPhasePhase(mPhasePhase), .mPhaseLast(mPhaseLast), .mPhaseUser(mPhaseUser));
   dds_stream_sink #(.W(46)) u_sink (.clk(clk), .rst(rst), .stall(stall), .valid(mDataValid),
      .beat(outBeat), .ready(rdy), .holdErrs(holdErrs));
   // single channel, no framing, no back-pressure: no tlast, input ready stays high
   dds_axi_stream_sideband u_dut_single (.clk(clk), .rst(rst), .aclken(aclken), .clearN(clearN),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hF), .pready(), .pslverr(), .prdata(), .sPhaseValid(1'b0),
      .sPhaseReady(singleReady), .sPhaseData(32'h0000_0000), .sPhaseLast(1'b0),
      .sPhaseUser(2'b00), .mDataValid(singleValid), .mDataReady(1'b0), .mDataData(),
      .mDataLast(singleLast), .mDataUser(), .mPhaseValid(), .mPhaseReady(1'b0),
      .mPhasePhase(), .mPhaseLast(), .mPhaseUser());

   // clock and cycle ceiling
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic check(input bit ok, input string msg);
      checks_done++;
      if (!ok)
      begin
         mismatches++;
         $display("ERROR %0t: %s", $time, msg);
      end
   endtask

   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(n == 1, "apb answer not in first access cycle");
   endtask

   // one upstream beat; expectation follows the per-channel accumulator
   task automatic send(input int ch, input logic [3:0] u, input logic [15:0] sh);
      int n;
      sPhaseValid <= 1'b1;
      sPhaseData <= {~sh, sh};
      sPhaseUser <= {u, 2'(ch)};
      sPhaseLast <= (ch == 3);
      n = 0;
      do begin @(posedge clk); n++; end while (!(sPhaseReady === 1'b1 && aclken) && n < 50);
      check(n < 50, "input beat not taken");
      expQ.push_back({acc[ch] + sh, acc[ch], {2{ch == 3}}, u, 2'(ch), 4'h0, 2'(ch)});
      acc[ch] = acc[ch] + act[ch];
      if (ch == 3)
         act = pend;
   endtask

   task automatic drain();
      int n;
      sPhaseValid <= 1'b0;
      n = 0;
      while (expQ.size() != 0 && n < 100) begin @(posedge clk); n++; end
      check(n < 100, "outputs not drained");
   endtask

   task automatic clear_model();
      for (int i = 0; i < 4; i++)
      begin
         acc[i] = '0;
         act[i] = '0;
         pend[i] = '0;
      end
   endtask

   // scoreboard on every output handshake
   always @(posedge clk)
   begin
      if (!rst && aclken === 1'b1 && mDataValid === 1'b1 && rdy === 1'b1)
      begin
         got = (expQ.size() != 0) ? expQ.pop_front() : '1;
         check(outBeat === got, "output beat differs");
         check(mPhaseValid === 1'b1, "phase output not valid with data");
      end
   end

   task automatic reg_scenario();
      apb(0, DDS_OFF_CTRL, 0);
      check(rd === DDS_CTRL_RESET && err === 1'b0, "control reset value");
      apb(0, 12'h020, 0);
      check(err === 1'b1 && rd === 32'h0000_0000, "unmapped read accepted");
      apb(1, DDS_OFF_CHAN_SEL, 32'h0000_0002);
      apb(0, DDS_OFF_CHAN_SEL, 0);
      check(rd[3:0] === 4'h2, "channel select readback");
      check(singleValid === 1'b1 && singleLast === 1'b0, "single channel carries tlast");
      check(singleReady === 1'b1, "input ready low without back-pressure");
   endtask

   task automatic stream_scenario();
      for (int ch = 0; ch < 4; ch++)
      begin
         apb(1, DDS_OFF_CHAN_SEL, 32'(ch));
         apb(1, DDS_OFF_STEP_LOAD, {16'h0000, STEPS[ch]});
         pend[ch] = STEPS[ch];
      end
      apb(0, DDS_OFF_STATUS, 0);
      check(rd[DDS_STAT_PEND_BIT] === 1'b1, "load not pending");
      stall <= 1'b1;
      for (int c = 0; c < 4; c++)
         for (int ch = 0; ch < 4; ch++)
            send(ch, 4'(c * 5 + ch), 16'(16'h1000 * ch + c));
      drain();
      stall <= 1'b0;
      apb(0, DDS_OFF_STATUS, 0);
      check(rd[DDS_STAT_PEND_BIT] === 1'b0, "pending not adopted");
      apb(1, DDS_OFF_CHAN_SEL, 32'h0000_0003);
      apb(0, DDS_OFF_STEP_LOAD, 0);
      check(rd[15:0] === STEPS[3], "active step of last channel");
   endtask

   task automatic enable_scenario();
      aclken <= 1'b0;
      fork
         send(0, 4'hA, 16'h0042);
         begin
            repeat (6)
            begin
               @(posedge clk);
               check(mDataValid === 1'b0, "output moved with enable low");
            end
            aclken <= 1'b1;
         end
      join
      drain();
   endtask

   task automatic clear_scenario();
      int n;
      clearN <= 1'b0;
      repeat (2) @(posedge clk);
      clearN <= 1'b1;
      repeat (4) @(posedge clk);
      n = 0;
      while (sPhaseReady !== 1'b1 && n < 20) begin @(posedge clk); n++; end
      check(n < 20, "input not ready after clear");
      clear_model();
      for (int ch = 0; ch < 4; ch++)
         send(ch, 4'h5, 16'h0F00 + 16'(ch));
      drain();
      check(holdErrs == 0, "stalled beat changed");
   endtask

   task automatic end_of_test();
      $display("mismatches %0d, checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // main sequence
   initial
   begin
      clear_model();
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reg_scenario();
      stream_scenario();
      enable_scenario();
      clear_scenario();
      end_of_test();
   end
endmodule
`default_nettype wire
